// >>> shared/tcp_pkg.sv
// Constants, register map and carrier type of the timer/counter with shared prescaler
package tcp_pkg;

  // =====================================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_COUNT   = 12'h000;
  localparam logic [11:0] ADDR_OPTION  = 12'h004;
  localparam logic [11:0] ADDR_INTCTL  = 12'h008;

  // =====================================================================
  // Field positions
  localparam int OPT_SRC_BIT    = 5;
  localparam int OPT_EDGE_BIT   = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_LSB  = 0;
  localparam int INT_EN_BIT     = 5;
  localparam int INT_FLAG_BIT   = 2;

  // =====================================================================
  // Reset values and counter maximum
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [5:0] OPTION_RESET = 6'h3F;
  localparam logic [7:0] PRESC_RESET  = 8'h00;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;

  // =====================================================================
  // Phase timing
  localparam int          PHASES_PER_CYCLE = 4;
  localparam logic [1:0]  PHASE_TWO        = 2'h1;
  localparam logic [1:0]  PHASE_FOUR       = 2'h3;
  localparam int          INHIBIT_CYCLES   = 2;
  localparam logic [3:0]  INHIBIT_CLOCKS   = 4'(INHIBIT_CYCLES * PHASES_PER_CYCLE);

  // =====================================================================
  // Carrier for the option bits
  typedef struct packed {
    logic       clock_source_select;
    logic       edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_ratio;
  } tcp_option_t;

endpackage

// >>> verilog/tcp_timer.sv
// Timer/counter with shared prescaler and APB register slave
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module tcp_timer (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_EXTERNAL_COUNT_PIN,
  input  wire logic        I_SLEEP,
  input  wire logic        I_WATCHDOG_CLEAR_INSTR,
  input  wire logic        I_WATCHDOG_TICK,
  output logic             O_WATCHDOG_TICK,
  output logic             O_OVERFLOW_IRQ
);

  // =====================================================================
  // Declarations
  tcp_pkg::tcp_option_t option_q;
  logic [7:0]  count_q;
  logic [7:0]  presc_q;
  logic        flag_q;
  logic        irq_en_q;
  logic [1:0]  phase_q;
  logic [3:0]  inhibit_q;
  logic        pin_meta_q;
  logic        pin_sync_q;
  logic        src_prev_q;
  logic        presc_prev_q;
  logic        samp_q;
  logic        samp_prev_q;
  logic        setup;
  logic        access;
  logic        mapped;
  logic        wr_count;
  logic        wr_option;
  logic        wr_intctl;
  logic        src_lvl;
  logic        src_rise;
  logic        presc_to_timer;
  logic        presc_step;
  logic        presc_clear;
  logic        presc_lvl;
  logic        sample_lvl;
  logic        sample_now;
  logic        inc;
  logic        overflow;

  // =====================================================================
  // APB slave: zero wait, answer in the first access cycle
  assign setup     = I_PSEL & ~I_PENABLE;
  assign access    = I_PSEL & I_PENABLE & O_PREADY;
  assign mapped    = (I_PADDR == tcp_pkg::ADDR_COUNT) | (I_PADDR == tcp_pkg::ADDR_OPTION) |
                     (I_PADDR == tcp_pkg::ADDR_INTCTL);
  assign wr_count  = access & I_PWRITE & (I_PADDR == tcp_pkg::ADDR_COUNT);
  assign wr_option = access & I_PWRITE & (I_PADDR == tcp_pkg::ADDR_OPTION);
  assign wr_intctl = access & I_PWRITE & (I_PADDR == tcp_pkg::ADDR_INTCTL);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= setup;
      O_PSLVERR <= setup & ~mapped;
    end
  end

  // Read data is captured in the setup cycle; the prescaler has no address
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup & ~I_PWRITE) begin
      O_PRDATA <= 32'h0000_0000;
      unique case (I_PADDR)
        tcp_pkg::ADDR_COUNT: begin
          O_PRDATA[7:0] <= count_q;
        end
        tcp_pkg::ADDR_OPTION: begin
          O_PRDATA[5:0] <= option_q;
        end
        tcp_pkg::ADDR_INTCTL: begin
          O_PRDATA[tcp_pkg::INT_EN_BIT]   <= irq_en_q;
          O_PRDATA[tcp_pkg::INT_FLAG_BIT] <= flag_q;
        end
        default: begin
          O_PRDATA <= 32'h0000_0000;
        end
      endcase
    end else if (O_PREADY) begin
      O_PRDATA <= 32'h0000_0000;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      option_q <= tcp_pkg::OPTION_RESET;
    end else if (wr_option) begin
      option_q <= I_PWDATA[5:0];
    end
  end

  // =====================================================================
  // Phase generator: four core clocks make one instruction cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // =====================================================================
  // Pin synchroniser
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= I_EXTERNAL_COUNT_PIN;
      pin_sync_q <= pin_meta_q;
    end
  end

  // =====================================================================
  // Source select and prescaler
  // Timer mode uses the instruction clock level, high in phases three and four
  assign src_lvl = option_q.clock_source_select ?
                   (pin_sync_q ^ option_q.edge_select) : phase_q[1];
  assign src_rise       = src_lvl & ~src_prev_q;
  assign presc_to_timer = ~option_q.prescaler_assign;
  assign presc_step     = presc_to_timer ? (src_rise & ~I_SLEEP) : I_WATCHDOG_TICK;
  assign presc_clear    = (wr_count & presc_to_timer) |
                          (I_WATCHDOG_CLEAR_INSTR & ~presc_to_timer);
  // Ratio n picks bit n, so 000 divides by 2 and 111 by 256
  assign presc_lvl      = presc_q[option_q.prescale_ratio];

  // Reset option selects the pin with falling edges, so the idle source level is
  // high; the edge history starts high to keep a false edge out after reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      src_prev_q <= 1'b1;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      presc_q <= tcp_pkg::PRESC_RESET;
    end else if (presc_clear) begin
      presc_q <= tcp_pkg::PRESC_RESET;
    end else if (presc_step) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // Watchdog tick leaves divided only while it owns the prescaler
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      presc_prev_q    <= 1'b0;
      O_WATCHDOG_TICK <= 1'b0;
    end else begin
      presc_prev_q    <= presc_lvl;
      O_WATCHDOG_TICK <= presc_to_timer ? I_WATCHDOG_TICK :
                         (presc_lvl & ~presc_prev_q & ~presc_clear);
    end
  end

  // =====================================================================
  // Phase two / four sampler of the prescaler output, or of the source while the watchdog owns the prescaler
  assign sample_lvl = presc_to_timer ? presc_lvl : src_lvl;
  assign sample_now = (phase_q == tcp_pkg::PHASE_TWO) | (phase_q == tcp_pkg::PHASE_FOUR);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      samp_q      <= 1'b1;
      samp_prev_q <= 1'b1;
    end else begin
      if (sample_now) begin
        samp_q <= sample_lvl;
      end
      samp_prev_q <= samp_q;
    end
  end

  // =====================================================================
  // Counter with write inhibit
  // A rising sample increments; sleep and the post-write window block it
  assign inc      = samp_q & ~samp_prev_q & ~I_SLEEP & (inhibit_q == 4'h0);
  assign overflow = inc & (count_q == tcp_pkg::COUNT_MAX);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      inhibit_q <= 4'h0;
    end else if (wr_count) begin
      inhibit_q <= tcp_pkg::INHIBIT_CLOCKS;
    end else if (inhibit_q != 4'h0) begin
      inhibit_q <= inhibit_q - 4'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      count_q <= tcp_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_q <= I_PWDATA[7:0];
    end else if (inc) begin
      count_q <= count_q + 8'h01;
    end
  end

  // =====================================================================
  // Overflow flag and request
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flag_q <= 1'b0;
    end else if (overflow) begin
      flag_q <= 1'b1;
    end else if (wr_intctl) begin
      flag_q <= I_PWDATA[tcp_pkg::INT_FLAG_BIT];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_en_q <= 1'b0;
    end else if (wr_intctl) begin
      irq_en_q <= I_PWDATA[tcp_pkg::INT_EN_BIT];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_OVERFLOW_IRQ <= 1'b0;
    end else begin
      O_OVERFLOW_IRQ <= flag_q & irq_en_q;
    end
  end

  // =====================================================================
  // Checks
  chk_write_inhibit_window: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    wr_count |=> (!inc)[*8])
    else $error("counter incremented inside write inhibit window");

  chk_presc_timer_clear: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    wr_count && presc_to_timer |=> presc_q == 8'h00)
    else $error("counter write did not clear prescaler");

  chk_presc_wdt_clear: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    I_WATCHDOG_CLEAR_INSTR && !presc_to_timer |=> presc_q == 8'h00)
    else $error("watchdog clear did not clear prescaler");

  chk_overflow_sets_flag: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    inc && count_q == 8'hFF && !wr_count |=> flag_q && count_q == 8'h00)
    else $error("rollover did not set overflow flag");

  chk_flag_sticky_hold: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    flag_q && !wr_intctl |=> flag_q)
    else $error("overflow flag dropped without software clear");

  chk_irq_mask_gate: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_OVERFLOW_IRQ |-> $past(flag_q) && $past(irq_en_q))
    else $error("request raised while masked or flag clear");

  chk_sleep_count_stop: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    I_SLEEP && !wr_count |=> $stable(count_q))
    else $error("counter moved during sleep");

  chk_inc_spacing_four: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    inc |=> (!inc)[*3])
    else $error("increments closer than one instruction cycle");

  chk_wdt_undivided_pass: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    presc_to_timer && I_WATCHDOG_TICK |=> O_WATCHDOG_TICK)
    else $error("watchdog tick not passed undivided");

  chk_timer_rate_plain: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (!option_q.clock_source_select && !presc_to_timer)[*4] ##0
    (!I_SLEEP && inhibit_q == 4'h0 && phase_q == 2'h0) |-> inc)
    else $error("timer mode missed instruction cycle increment");

endmodule

// >>> test/tcp_pin_src.sv
// Behavioural source of the external count pin
`timescale 1ns/100ps
module tcp_pin_src (
  input  wire logic i_clk,
  output logic      o_pin
);
  initial o_pin = 1'b0;
  // Each level is held 12 periods, well over the two-period minimum,
  // so that the phase-two/four sampling catches every level
  task automatic drive(input logic v);
    @(posedge i_clk);
    o_pin <= v;
    repeat (12) @(posedge i_clk);
  endtask
endmodule

// >>> test/test_tcp_timer.sv
// Self-checking bench of the timer/counter with shared prescaler
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module test_tcp_timer;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
  logic        pready, pslverr, re, pin, sleep = 1'b0, wclr = 1'b0, wtick = 1'b0;
  logic        o_wd, irq;
  int          error_cnt = 0, n_tests = 0, cyc = 0, wdn = 0, a;

  // =====================================================================
  // Clock, partner and design
  always #5 clk = ~clk;
  tcp_pin_src i_src (.i_clk(clk), .o_pin(pin));
  tcp_timer i_dut (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EXTERNAL_COUNT_PIN(pin),
    .I_SLEEP(sleep), .I_WATCHDOG_CLEAR_INSTR(wclr), .I_WATCHDOG_TICK(wtick),
    .O_WATCHDOG_TICK(o_wd), .O_OVERFLOW_IRQ(irq));
  always @(posedge clk) begin
    if (o_wd === 1'b1) wdn++;
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // =====================================================================
  // Bus and stimulus tasks
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic w(input logic [11:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic r(input logic [11:0] ad);
    apb(1'b0, ad, 8'h00);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk);
      wtick <= 1'b1;
      @(posedge clk);
      wtick <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic wd_clear();
    @(posedge clk);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
    wdn = 0;
  endtask
  task automatic pulse_cnt();
    i_src.drive(1'b0);
    i_src.drive(1'b1);
    r(tcp_pkg::ADDR_COUNT);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_reset();
    r(tcp_pkg::ADDR_OPTION); `CHK(rv, 32'h0000_003F)
    r(tcp_pkg::ADDR_COUNT);  `CHK(rv, 32'h0000_0000)
    r(tcp_pkg::ADDR_INTCTL); `CHK(rv, 32'h0000_0000)
    r(12'h0FC);              `CHK({re, rv}, 33'h0_0000_0000 | 33'h1_0000_0000)
    $display("reset test done");
  endtask
  task automatic t_timer();
    w(tcp_pkg::ADDR_OPTION, 8'h08);
    w(tcp_pkg::ADDR_COUNT, 8'hFD);
    r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0], 8'hFD)
    repeat (30) @(posedge clk);
    r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0] inside {[8'h02:8'h04]}, 1'b1)
    r(tcp_pkg::ADDR_INTCTL); `CHK(rv[7:0], 8'h04)
    `CHK(irq, 1'b0)
    w(tcp_pkg::ADDR_INTCTL, 8'h24);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    repeat (20) @(posedge clk);
    r(tcp_pkg::ADDR_INTCTL); `CHK(rv[2], 1'b1)
    w(tcp_pkg::ADDR_INTCTL, 8'h00);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    r(tcp_pkg::ADDR_INTCTL); `CHK(rv[7:0], 8'h00)
    $display("timer test done");
  endtask
  task automatic t_sleep();
    sleep <= 1'b1;
    w(tcp_pkg::ADDR_COUNT, 8'h10);
    repeat (40) @(posedge clk);
    r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0], 8'h10)
    sleep <= 1'b0;
    $display("sleep test done");
  endtask
  task automatic t_ratio();
    for (int k = 0; k < 8; k++) begin
      w(tcp_pkg::ADDR_OPTION, 8'(k));
      w(tcp_pkg::ADDR_COUNT, 8'h00);
      repeat (16 << (k + 1)) @(posedge clk);
      r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0] inside {[8'h03:8'h05]}, 1'b1)
    end
    $display("ratio test done");
  endtask
  task automatic t_pin();
    w(tcp_pkg::ADDR_OPTION, 8'h28);
    w(tcp_pkg::ADDR_COUNT, 8'h00);
    repeat (8) @(posedge clk);
    i_src.drive(1'b1);
    r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0], 8'h01)
    pulse_cnt(); `CHK(rv[7:0], 8'h02)
    w(tcp_pkg::ADDR_OPTION, 8'h38);
    r(tcp_pkg::ADDR_COUNT);
    a = rv[7:0];
    i_src.drive(1'b1);
    r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0], 8'(a))
    i_src.drive(1'b0);
    r(tcp_pkg::ADDR_COUNT); `CHK(rv[7:0], 8'(a + 1))
    wd_clear();
    w(tcp_pkg::ADDR_OPTION, 8'h20);
    w(tcp_pkg::ADDR_COUNT, 8'h00);
    pulse_cnt();
    a = rv[7:0];
    w(tcp_pkg::ADDR_COUNT, 8'h00);
    pulse_cnt(); `CHK(rv[7:0], 8'(a))
    pulse_cnt();
    pulse_cnt(); `CHK(rv[7:0], 8'(a + 1))
    $display("pin test done");
  endtask
  task automatic t_wdog();
    w(tcp_pkg::ADDR_OPTION, 8'h00);
    wd_clear();
    ticks(5); `CHK(wdn, 5)
    wd_clear();
    w(tcp_pkg::ADDR_COUNT, 8'h00);
    w(tcp_pkg::ADDR_OPTION, 8'h09);
    wd_clear();
    ticks(8); `CHK(wdn, 2)
    wd_clear();
    ticks(2);
    a = wdn;
    wd_clear();
    ticks(2); `CHK(wdn, a)
    $display("watchdog test done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_timer();
    t_sleep();
    t_ratio();
    t_pin();
    t_wdog();
    report_and_stop();
  end
endmodule
